// ---- hw/ppl_pkg.sv ----
// Purpose: shared constants for the passive parallel configuration load link
// Assumes: core clock of 40 MHz on both ends
// Notes: times are kept in their own unit, cycle counts derive from them
package ppl_pkg;
    localparam int CLK_MHZ = 40;
    localparam int CLK_NS = 25;
    // least times round up, longest times round down
    localparam int T_CFG_REQ_MIN_NS = 2000;
    localparam int CYC_CFG_REQ_MIN = (T_CFG_REQ_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_REACT_MAX_NS = 600;
    localparam int CYC_REACT_MAX = T_REACT_MAX_NS / CLK_NS;
    localparam int T_STATUS_MIN_US = 268;
    localparam int CYC_STATUS_MIN = T_STATUS_MIN_US * CLK_MHZ;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int CYC_STATUS_MAX = T_STATUS_MAX_US * CLK_MHZ;
    localparam int T_ST2CK_MIN_US = 2;
    localparam int CYC_ST2CK_MIN = T_ST2CK_MIN_US * CLK_MHZ;
    localparam int T_CF2CK_MIN_US = 1506;
    localparam int CYC_CF2CK_MIN = T_CF2CK_MIN_US * CLK_MHZ;
    localparam int T_USER_MIN_US = 175;
    localparam int CYC_USER_MIN = T_USER_MIN_US * CLK_MHZ;
    localparam int T_USER_MAX_US = 437;
    localparam int CYC_USER_MAX = T_USER_MAX_US * CLK_MHZ;
    localparam int T_POR_US = 268;
    localparam int CYC_POR = T_POR_US * CLK_MHZ;
    localparam int POST_DONE_FALLS = 2;
    localparam int WORDS_PER_CLOCK = 1;
    localparam int DATA_W_MAX = 16;
    localparam int STREAM_WORDS = 64;
    localparam int CNT_W = 32;
    localparam int OPT_WORD_IDX = 0;
    localparam int OPT_INIT_BIT = 0;
    localparam int LINK_HALF_DIV = 4;
    localparam logic [1:0] SYNC_RST = 2'h3;
endpackage

// ---- hw/ppl_link_if.sv ----
// Purpose: pins between configuration host and device
// Assumes: status and complete are open drain with pull-ups
// Notes: wire levels are resolved here from the output enables
`timescale 1ns/10ps
`default_nettype none
interface ppl_link_if;
    logic config_request_n;
    logic config_clock;
    logic [15:0] data;
    logic dev_status_oe;
    logic dev_complete_oe;
    logic host_status_oe;
    logic init_complete;
    logic config_status_n;
    logic config_complete;
    assign config_status_n = !(dev_status_oe || host_status_oe);
    assign config_complete = !dev_complete_oe;
    modport device (
        input config_request_n, config_clock, data, config_status_n, config_complete,
        output dev_status_oe, dev_complete_oe, init_complete
    );
    modport host (
        input config_status_n, config_complete, init_complete,
        output config_request_n, config_clock, data, host_status_oe
    );
endinterface
`default_nettype wire

// ---- hw/ppl_device.sv ----
// Purpose: device end of the passive parallel configuration load
// Assumes: link pins arrive asynchronous and are synchronised on core_clk
// Notes: configuration is the counted word stream; option word sets init pin use
`timescale 1ns/10ps
`default_nettype none
module ppl_device
    import ppl_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int WORDS = STREAM_WORDS,
    parameter int POR_CYC = CYC_POR,
    parameter int STATUS_CYC = CYC_STATUS_MIN,
    parameter int INIT_CYC = CYC_USER_MIN
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    ppl_link_if.device link,
    // user side
    output logic user_mode,
    output logic load_error,
    output logic [DATA_W-1:0] word_data,
    output logic word_valid
);
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_RESET = 3'b001,
        ST_LOAD = 3'b010,
        ST_DONE = 3'b011,
        ST_INIT = 3'b100,
        ST_USER = 3'b101
    } ppl_dev_state_e;

    ppl_dev_state_e state_q;
    logic [1:0] req_s_q, clk_s_q, sts_s_q, cpl_s_q;
    logic [DATA_W-1:0] dat_m_q, dat_s_q;
    logic req_d1_q, clk_d1_q;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] words_q;
    logic [1:0] falls_q;
    logic init_opt_q;
    logic req_n, clk_rise, clk_fall, req_fall;

    // two-flop synchronisers; only the second stage is read by logic
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s_q <= SYNC_RST;
            clk_s_q <= 2'h0;
            sts_s_q <= SYNC_RST;
            cpl_s_q <= 2'h0;
            dat_m_q <= '0;
            dat_s_q <= '0;
        end else begin
            req_s_q <= {req_s_q[0], link.config_request_n};
            clk_s_q <= {clk_s_q[0], link.config_clock};
            sts_s_q <= {sts_s_q[0], link.config_status_n};
            cpl_s_q <= {cpl_s_q[0], link.config_complete};
            dat_m_q <= link.data[DATA_W-1:0];
            dat_s_q <= dat_m_q;
        end
    end
    assign req_n = req_s_q[1];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_d1_q <= 1'b1;
            clk_d1_q <= 1'b0;
        end else begin
            req_d1_q <= req_n;
            clk_d1_q <= clk_s_q[1];
        end
    end
    assign clk_rise = clk_s_q[1] && !clk_d1_q;
    assign clk_fall = !clk_s_q[1] && clk_d1_q;
    assign req_fall = !req_n && req_d1_q;

    // state machine; request low wins in any state but ST_POR, giving reconfiguration
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_POR;
            tmr_q <= '0;
        end else if (state_q != ST_POR && !req_n) begin
            state_q <= ST_RESET;
            tmr_q <= '0;
        end else begin
            case (state_q)
                ST_POR: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q >= CNT_W'(POR_CYC - 1)) begin
                        state_q <= ST_RESET;
                        tmr_q <= '0;
                    end
                end
                ST_RESET: begin
                    // request is high here; clear-time well under the 1506 us limit
                    if (tmr_q < CNT_W'(STATUS_CYC)) begin
                        tmr_q <= tmr_q + 1'b1;
                    end else if (sts_s_q[1]) begin
                        state_q <= ST_LOAD;
                        tmr_q <= '0;
                    end
                end
                ST_LOAD: begin
                    if (words_q == CNT_W'(WORDS)) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (falls_q == 2'(POST_DONE_FALLS)) begin
                        state_q <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q >= CNT_W'(INIT_CYC - 1)) begin
                        state_q <= ST_USER;
                    end
                end
                ST_USER: begin
                    state_q <= ST_USER;
                end
                default: begin
                    state_q <= ST_POR;
                end
            endcase
        end
    end

    // word capture and count, one word per rising clock edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            words_q <= '0;
            word_valid <= 1'b0;
            word_data <= '0;
            init_opt_q <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (state_q != ST_LOAD) begin
                words_q <= (state_q == ST_RESET) ? '0 : words_q;
            end else if (clk_rise && words_q < CNT_W'(WORDS)) begin
                words_q <= words_q + 1'b1;
                word_data <= dat_s_q;
                word_valid <= 1'b1;
                if (words_q == CNT_W'(OPT_WORD_IDX)) begin
                    init_opt_q <= dat_s_q[OPT_INIT_BIT];
                end
            end
            if (state_q == ST_RESET) begin
                init_opt_q <= 1'b0;
            end
        end
    end

    // falling edges after completion
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            falls_q <= '0;
        end else if (state_q != ST_DONE) begin
            falls_q <= '0;
        end else if (clk_fall && cpl_s_q[1] && falls_q != 2'(POST_DONE_FALLS)) begin
            // complete level lags like the clock, so the last word's fall is not counted
            falls_q <= falls_q + 1'b1;
        end
    end

    // pin drivers; req_fall path acts in one cycle after sync, far under 600 ns
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.dev_status_oe <= 1'b1;
            link.dev_complete_oe <= 1'b1;
            link.init_complete <= 1'b1;
            user_mode <= 1'b0;
            load_error <= 1'b0;
        end else begin
            // status is let go after the minimum so the line can rise and be seen high
            link.dev_status_oe <= (state_q == ST_POR) || req_fall || !req_n
                || (state_q == ST_RESET && tmr_q < CNT_W'(STATUS_CYC));
            link.dev_complete_oe <= !req_n || req_fall
                || !(state_q inside {ST_DONE, ST_INIT, ST_USER});
            link.init_complete <= !(init_opt_q && (state_q inside {ST_DONE, ST_INIT}));
            user_mode <= (state_q == ST_USER) && req_n;
            load_error <= (state_q == ST_LOAD) && !req_n;
        end
    end
endmodule
`default_nettype wire

// ---- hw/ppl_host.sv ----
// Purpose: host end, drives request, clock and words of the stream
// Assumes: words come from a user source with valid and ready
// Notes: link clock comes from a divider of core_clk
`timescale 1ns/10ps
`default_nettype none
module ppl_host
    import ppl_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int WORDS = STREAM_WORDS,
    parameter int CF2CK_CYC = CYC_CF2CK_MIN,
    parameter int REQ_CYC = CYC_CFG_REQ_MIN
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    ppl_link_if.host link,
    // user side
    input wire logic start,
    input wire logic [DATA_W-1:0] src_data,
    input wire logic src_valid,
    output logic src_ready,
    output logic busy,
    output logic done
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_REQ = 3'b001,
        H_WAIT = 3'b010,
        H_SEND = 3'b011,
        H_TAIL = 3'b100
    } ppl_host_state_e;

    ppl_host_state_e state_q;
    logic [1:0] sts_s_q, cd_s_q;
    logic sts_d1_q;
    logic [CNT_W-1:0] tmr_q, sts_tmr_q, words_q;
    logic [3:0] div_q;
    logic [1:0] falls_q;
    logic tick;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sts_s_q <= 2'h0;
            cd_s_q <= 2'h0;
            sts_d1_q <= 1'b0;
        end else begin
            sts_s_q <= {sts_s_q[0], link.config_status_n};
            cd_s_q <= {cd_s_q[0], link.config_complete};
            sts_d1_q <= sts_s_q[1];
        end
    end

    assign tick = (div_q == 4'(LINK_HALF_DIV - 1));
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    // status release timer; first edge waits the later of both limits
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sts_tmr_q <= '0;
        end else if (!sts_s_q[1] || (sts_s_q[1] && !sts_d1_q)) begin
            sts_tmr_q <= '0;
        end else if (sts_tmr_q != CNT_W'(CYC_ST2CK_MIN)) begin
            sts_tmr_q <= sts_tmr_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            tmr_q <= '0;
            words_q <= '0;
            falls_q <= '0;
            link.config_request_n <= 1'b1;
            link.config_clock <= 1'b0;
            link.data <= '0;
            link.host_status_oe <= 1'b0;
            src_ready <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            src_ready <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (start) begin
                        link.config_request_n <= 1'b0;
                        state_q <= H_REQ;
                        tmr_q <= '0;
                        busy <= 1'b1;
                        done <= 1'b0;
                    end
                end
                H_REQ: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q >= CNT_W'(REQ_CYC)) begin
                        link.config_request_n <= 1'b1;
                        state_q <= H_WAIT;
                        tmr_q <= '0;
                    end
                end
                H_WAIT: begin
                    if (tmr_q < CNT_W'(CF2CK_CYC)) begin
                        tmr_q <= tmr_q + 1'b1;
                    end else if (sts_s_q[1] && sts_tmr_q == CNT_W'(CYC_ST2CK_MIN) && tick) begin
                        state_q <= H_SEND;
                        words_q <= '0;
                    end
                end
                H_SEND: begin
                    // data is driven in the same cycle the clock rises; the rising edge is the capture edge
                    if (tick) begin
                        if (!link.config_clock) begin
                            if (words_q == CNT_W'(WORDS)) begin
                                state_q <= H_TAIL;
                                falls_q <= '0;
                            end else if (src_valid) begin
                                link.data <= 16'(src_data);
                                link.config_clock <= 1'b1;
                                src_ready <= 1'b1;
                                words_q <= words_q + 1'b1;
                            end
                        end else begin
                            link.config_clock <= 1'b0;
                        end
                    end
                end
                H_TAIL: begin
                    if (tick && cd_s_q[1]) begin
                        if (falls_q == 2'(POST_DONE_FALLS)) begin
                            state_q <= H_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end else if (link.config_clock) begin
                            link.config_clock <= 1'b0;
                            falls_q <= falls_q + 1'b1;
                        end else begin
                            link.config_clock <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- testbench/ppl_asserts.sv ----
// Purpose: wire-level checks of the configuration link
// Assumes: both ends are design code on one 40 MHz core clock
// Notes: level-time counters saturate so long idle stretches stay legal
`timescale 1ns/10ps
`default_nettype none
module ppl_asserts
    import ppl_pkg::*;
#(
    parameter int REQ_CYC = CYC_CFG_REQ_MIN,
    parameter int STATUS_CYC = CYC_STATUS_MIN,
    parameter int CF2CK_CYC = CYC_CF2CK_MIN,
    parameter int WORDS = STREAM_WORDS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link levels
    input wire logic config_request_n,
    input wire logic config_clock,
    input wire logic [15:0] data,
    input wire logic config_status_n,
    input wire logic config_complete
);
    localparam int REACT = CYC_REACT_MAX;
    localparam int SAT = 32'h0FFFFFFF;
    int req_lo_cnt, req_hi_cnt, st_lo_cnt, st_hi_cnt, rise_cnt, fall_cnt;
    logic clk_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_lo_cnt <= 0;
            req_hi_cnt <= 0;
            st_lo_cnt <= 0;
            st_hi_cnt <= 0;
        end else begin
            req_lo_cnt <= config_request_n ? 0 : (req_lo_cnt < SAT ? req_lo_cnt + 1 : SAT);
            req_hi_cnt <= !config_request_n ? 0 : (req_hi_cnt < SAT ? req_hi_cnt + 1 : SAT);
            st_lo_cnt <= config_status_n ? 0 : (st_lo_cnt < SAT ? st_lo_cnt + 1 : SAT);
            st_hi_cnt <= !config_status_n ? 0 : (st_hi_cnt < SAT ? st_hi_cnt + 1 : SAT);
        end
    end

    // edges seen through core_clk, as the device itself sees them
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_q <= 1'b0;
            rise_cnt <= 0;
            fall_cnt <= 0;
        end else begin
            clk_q <= config_clock;
            rise_cnt <= !config_request_n ? 0 : rise_cnt + int'(config_clock && !clk_q);
            fall_cnt <= !config_complete ? 0 : fall_cnt + int'(!config_clock && clk_q);
        end
    end

    sequence s_req_fall;
        $fell(config_request_n);
    endsequence
    sequence s_two_falls;
        fall_cnt == POST_DONE_FALLS;
    endsequence

    a_complete_drop_fast: assert property (s_req_fall |-> ##[1:REACT] !config_complete)
        else $error("complete not low in time after request");
    a_status_drop_fast: assert property (s_req_fall |-> ##[1:REACT] !config_status_n)
        else $error("status not low in time after request");
    a_req_low_width: assert property ($rose(config_request_n) |-> req_lo_cnt >= REQ_CYC)
        else $error("request low pulse too short");
    a_status_low_min: assert property ($rose(config_status_n) |-> st_lo_cnt >= STATUS_CYC)
        else $error("status low pulse too short");
    a_status_low_max: assert property (st_lo_cnt <= CYC_STATUS_MAX)
        else $error("status held low too long");
    a_complete_word_count: assert property ($rose(config_complete) |-> rise_cnt == WORDS)
        else $error("complete rose at wrong word count");
    a_post_falls: assert property ($rose(config_complete) |-> ##[1:100] s_two_falls)
        else $error("two falling clocks missing after complete");
    a_data_hold_high: assert property (config_clock && $past(config_clock) |-> $stable(data))
        else $error("data moved while clock high");
    a_clk_after_req: assert property ($rose(config_clock) |-> req_hi_cnt >= CF2CK_CYC)
        else $error("clock rose too soon after request release");
    a_clk_after_status: assert property ($rose(config_clock) |-> st_hi_cnt >= CYC_ST2CK_MIN)
        else $error("clock rose too soon after status release");
endmodule
`default_nettype wire

// ---- testbench/parallel_passive_config_load_tb.sv ----
// Purpose: host and device joined by the link, full loads and restarts
// Assumes: shortened counts, word 0 bit 0 is the init option
// Notes: words carry a counting pattern in both bytes
`timescale 1ns/10ps
`default_nettype none
module parallel_passive_config_load_tb;
    import ppl_pkg::*;
    localparam int WORDS = 8;
    localparam int POR_CYC = 50;
    localparam int STATUS_CYC = 50;
    localparam int INIT_CYC = 20;
    localparam int CF2CK_CYC = 100;
    localparam int REQ_CYC = 80;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] src_data = 16'h0000;
    logic src_valid = 1'b0;
    logic opt = 1'b0;
    logic src_ready, busy, done, user_mode, load_error, word_valid;
    logic [15:0] word_data;
    int n_fail = 0;
    int checks = 0;
    int idx = 0;
    int got = 0;

    ppl_link_if link ();
    ppl_host #(.DATA_W(16), .WORDS(WORDS), .CF2CK_CYC(CF2CK_CYC), .REQ_CYC(REQ_CYC)) ppl_host_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .start(start),
        .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
        .busy(busy), .done(done));
    ppl_device #(.DATA_W(16), .WORDS(WORDS), .POR_CYC(POR_CYC), .STATUS_CYC(STATUS_CYC),
        .INIT_CYC(INIT_CYC)) ppl_device_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .link(link), .user_mode(user_mode),
        .load_error(load_error), .word_data(word_data), .word_valid(word_valid));
    ppl_asserts #(.REQ_CYC(REQ_CYC), .STATUS_CYC(STATUS_CYC), .CF2CK_CYC(CF2CK_CYC),
        .WORDS(WORDS)) ppl_asserts_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .config_request_n(link.config_request_n),
        .config_clock(link.config_clock), .data(link.data),
        .config_status_n(link.config_status_n), .config_complete(link.config_complete));

    always #12.5 core_clk = ~core_clk;

    function automatic logic [15:0] exp_word(input int i);
        return (16'h5A00 + 16'h0102 * 16'(i)) | {15'h0000, opt && i == 0};
    endfunction

    function automatic logic cond(input int sel);
        case (sel)
            0: return link.config_status_n === 1'b1;
            1: return done === 1'b1;
            3: return got >= WORDS / 2;
            default: return user_mode === 1'b1;
        endcase
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // bounded wait; running out ends the run as a mismatch
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        while (!cond(sel) && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (!cond(sel)) begin
            n_fail++;
            $display("[ERR] %0t wait %h limit %h", $time, sel, lim);
            end_of_test();
        end
    endtask

    // source advances one word per taken word, so no word is sent twice
    always @(posedge core_clk) begin
        if (src_ready === 1'b1) begin
            idx <= idx + 1;
            src_data <= exp_word(idx + 1);
        end
    end

    always @(posedge core_clk) begin
        if (word_valid === 1'b1) begin
            chk(word_data, exp_word(got));
            got = got + 1;
        end
    end

    task automatic kick(input logic o);
        @(posedge core_clk);
        opt <= o;
        idx <= 0;
        got = 0;
        src_valid <= 1'b1;
        src_data <= 16'h5A00 | {15'h0000, o};
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (REQ_CYC / 2) @(posedge core_clk);
        chk(16'(user_mode), 16'h0000);
        chk(16'(busy), 16'h0001);
        chk(16'(link.config_complete), 16'h0000);
    endtask

    task automatic run_load(input logic o);
        kick(o);
        wait_for(1, 20000);
        chk(16'(got), 16'(WORDS));
        chk(16'(busy), 16'h0000);
        chk(16'(link.init_complete), {15'h0000, !o});
        wait_for(2, INIT_CYC + 40);
        chk({13'h0000, link.config_request_n, link.config_status_n, link.config_complete},
            16'h0007);
        chk(16'(link.init_complete), 16'h0001);
        chk(16'(load_error), 16'h0000);
    endtask

    task automatic power_up();
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (POR_CYC - 10) @(posedge core_clk);
        chk(16'(link.config_status_n), 16'h0000);
        chk(16'(link.config_complete), 16'h0000);
        wait_for(0, 200);
    endtask

    initial begin
        power_up();
        $display("test power_up done");
        run_load(1'b0);
        $display("test load_plain done");
        run_load(1'b1);
        $display("test reload_with_init done");
        // reset in mid-stream must restart the power-on hold
        kick(1'b0);
        wait_for(3, 20000);
        sys_rst <= 1'b1;
        power_up();
        chk(16'(user_mode), 16'h0000);
        chk(16'(link.config_complete), 16'h0000);
        run_load(1'b0);
        $display("test reset_mid_load done");
        end_of_test();
    end
endmodule
`default_nettype wire
